// ### rtl/rgcr_top.sv
// Summary of operation
// - Override enable applies software amplifier gain
// - Gain field: write override, read gain used
// - Mode override: auto, low, mid, high
// - Status field shows mode in use
// - Mode switching uses hysteresis, 2 dB units
// - Mid/high switch threshold, reset 25
// - Low/mid switch threshold, reset 9
// - Auto: blank on 14 dB drop unless disabled
// - Override: blank only when select bit set
// - Bit doubles peak detector bias current
// - Wait settle interval after gain change
// - Three bits enable individual peak detectors
// - Window length 8, 16, 32, 64 samples
// - Loop regulates toward target level
// - Mid to high gain step compensation
// - Low to mid gain step compensation
`timescale 1ns/100ps
`default_nettype none
module rgcr_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output var  logic [15:0] reg_rdata,
    input  wire logic        rx_active,
    input  wire logic        det_valid,
    input  wire logic [5:0]  det_adc_level,
    input  wire logic [5:0]  det_fixed_level,
    input  wire logic [5:0]  det_var_level,
    output var  logic [6:0]  vga_gain_out,
    output var  logic [1:0]  frontend_mode_out,
    output var  logic [2:0]  detector_enable_out,
    output var  logic        detector_bias_double_out,
    output var  logic        vga_blank_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 ovr_en;
        logic [6:0]           vga_ovr;
        logic [1:0]           mode_ovr;
        rgcr_pkg::rgcr_thr_t  thr;
        rgcr_pkg::rgcr_loop_t lset;
        rgcr_pkg::rgcr_step_t step;
        logic [6:0]           loop_vga;
        logic [1:0]           auto_mode;
        logic [6:0]           vga_out;
        logic [1:0]           mode_out;
        logic                 blank;
        logic                 settle_go;
        logic                 smp_valid;
        logic [5:0]           smp_level;
        logic [15:0]          rdata;
    } rgcr_top_st_t;

    rgcr_top_st_t q;
    rgcr_top_st_t d;

    rgcr_loop_if lp ();

    rgcr_accum u_accum (
        .clk (clk),
        .rst (rst),
        .lp  (lp.acc)
    );

    rgcr_settle u_settle (
        .clk (clk),
        .rst (rst),
        .lp  (lp.settle)
    );

    rgcr_pkg::rgcr_ctrl_t       wctrl;
    rgcr_pkg::rgcr_ctrl_t       rctrl;
    logic [5:0]                 lvl;
    logic                       settling;
    logic signed [8:0]          err;
    logic signed [8:0]          nv;
    logic signed [8:0]          hy;
    logic signed [8:0]          th_h;
    logic signed [8:0]          th_l;
    logic signed [8:0]          m2h;
    logic signed [8:0]          l2m;
    logic signed [8:0]          drop;
    logic [1:0]                 mode;
    logic [6:0]                 av;
    logic [1:0]                 am;
    logic                       falls;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d           = q;
        d.settle_go = 1'b0;
        wctrl       = rgcr_pkg::rgcr_ctrl_t'(reg_wdata);
        settling    = q.settle_go | lp.settle_busy;

        // Register writes; reserved bits are not stored
        if (reg_wr) begin
            case (reg_addr)
                rgcr_pkg::ADDR_CTRL: begin
                    d.ovr_en   = wctrl.vga_override_en;
                    d.vga_ovr  = wctrl.vga_gain;
                    d.mode_ovr = wctrl.frontend_mode_override;
                end
                rgcr_pkg::ADDR_THR: begin
                    d.thr = rgcr_pkg::rgcr_thr_t'(reg_wdata);
                end
                rgcr_pkg::ADDR_LOOP: begin
                    d.lset      = rgcr_pkg::rgcr_loop_t'(reg_wdata);
                    d.lset.rsvd = 1'b0;
                end
                rgcr_pkg::ADDR_STEP: begin
                    d.step      = rgcr_pkg::rgcr_step_t'(reg_wdata);
                    d.step.rsvd = '0;
                end
                default: begin
                end
            endcase
        end

        // Strongest level among the enabled detectors
        lvl = '0;
        if (q.lset.detector_enable_set[2] && det_adc_level > lvl) begin
            lvl = det_adc_level;
        end
        if (q.lset.detector_enable_set[1] && det_fixed_level > lvl) begin
            lvl = det_fixed_level;
        end
        if (q.lset.detector_enable_set[0] && det_var_level > lvl) begin
            lvl = det_var_level;
        end
        d.smp_valid = det_valid & rx_active & (|q.lset.detector_enable_set);
        d.smp_level = lvl;

        // ------------------------------------------------------------
        // Loop update at each window dump outside gain override and settling
        // ------------------------------------------------------------
        hy   = {5'h00, q.thr.frontend_mode_hysteresis};
        th_h = {3'h0, q.thr.mid_high_threshold};
        th_l = {3'h0, q.thr.low_mid_threshold};
        m2h  = {4'h0, q.step.mid_to_high_gain_step};
        l2m  = {4'h0, q.step.low_to_mid_gain_step};
        err  = {3'h0, q.lset.loop_target_level} - {3'h0, lp.dump_level};
        nv   = {2'h0, q.loop_vga} + err;
        mode = q.auto_mode;
        if (mode == rgcr_pkg::MODE_AUTO) begin
            mode = rgcr_pkg::MODE_HIGH;
        end
        if (rx_active && q.auto_mode == rgcr_pkg::MODE_AUTO) begin
            d.auto_mode = rgcr_pkg::MODE_HIGH;
        end
        if (rx_active && lp.dump_valid && !settling && !q.ovr_en) begin
            case (mode)
                rgcr_pkg::MODE_HIGH: begin
                    if (nv < th_h - hy) begin
                        mode = rgcr_pkg::MODE_MID;
                        nv   = nv + m2h;
                    end
                end
                rgcr_pkg::MODE_MID: begin
                    if (nv > th_h + hy) begin
                        mode = rgcr_pkg::MODE_HIGH;
                        nv   = nv - m2h;
                    end else if (nv < th_l - hy) begin
                        mode = rgcr_pkg::MODE_LOW;
                        nv   = nv + l2m;
                    end
                end
                rgcr_pkg::MODE_LOW: begin
                    if (nv > th_l + hy) begin
                        mode = rgcr_pkg::MODE_MID;
                        nv   = nv - l2m;
                    end
                end
                default: begin
                end
            endcase
            if (nv < 9'sh000) begin
                nv = 9'sh000;
            end else if (nv > rgcr_pkg::VGA_MAX) begin
                nv = rgcr_pkg::VGA_MAX;
            end
            d.loop_vga  = 7'(nv);
            d.auto_mode = mode;
        end

        // ------------------------------------------------------------
        // Applied gain and mode
        // ------------------------------------------------------------
        av = q.ovr_en ? q.vga_ovr : d.loop_vga;
        am = d.auto_mode;
        if (q.mode_ovr != rgcr_pkg::MODE_AUTO) begin
            am = q.mode_ovr;
        end
        drop  = {2'h0, q.vga_out} - {2'h0, av};
        falls = (drop >= rgcr_pkg::STAGE_DROP) ||
                (am < q.mode_out && am != rgcr_pkg::MODE_AUTO);
        if (av != q.vga_out || am != q.mode_out) begin
            d.settle_go = 1'b1;
        end
        d.vga_out  = av;
        d.mode_out = am;

        // Blanking held while the new gain settles
        if (falls && !q.ovr_en && !q.lset.blanking_select) begin
            d.blank = 1'b1;
        end else if (falls && q.ovr_en && q.lset.blanking_select) begin
            d.blank = 1'b1;
        end else if (!settling) begin
            d.blank = 1'b0;
        end

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        rctrl                        = '0;
        rctrl.vga_override_en        = q.ovr_en;
        rctrl.vga_gain               = q.vga_out;
        rctrl.frontend_mode_override = q.mode_ovr;
        rctrl.frontend_mode_current  = q.mode_out;
        if (reg_rd) begin
            case (reg_addr)
                rgcr_pkg::ADDR_CTRL: d.rdata = 16'(rctrl);
                rgcr_pkg::ADDR_THR:  d.rdata = 16'(q.thr);
                rgcr_pkg::ADDR_LOOP: d.rdata = 16'(q.lset);
                rgcr_pkg::ADDR_STEP: d.rdata = 16'(q.step);
                default:             d.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            q          <= '0;
            q.vga_ovr  <= rgcr_pkg::VGA_RESET;
            q.loop_vga <= rgcr_pkg::VGA_RESET;
            q.vga_out  <= rgcr_pkg::VGA_RESET;
            q.thr      <= rgcr_pkg::THR_RESET;
            q.lset     <= rgcr_pkg::LOOP_RESET;
            q.step     <= rgcr_pkg::STEP_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Loop interface and outputs
    // ------------------------------------------------------------
    assign lp.smp_valid    = q.smp_valid;
    assign lp.smp_level    = q.smp_level;
    assign lp.win_sel      = q.lset.accumulate_window_len;
    assign lp.acc_clear    = q.settle_go | lp.settle_busy | ~rx_active;
    assign lp.settle_start = q.settle_go;
    assign lp.settle_sel   = q.lset.gain_settle_time;

    assign reg_rdata                = q.rdata;
    assign vga_gain_out             = q.vga_out;
    assign frontend_mode_out        = q.mode_out;
    assign detector_enable_out      = q.lset.detector_enable_set;
    assign detector_bias_double_out = q.lset.detector_bias_double;
    assign vga_blank_out            = q.blank;

endmodule // rgcr_top
`default_nettype wire

// ### rtl/rgcr_pkg.sv
`default_nettype none
package rgcr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_CTRL = 6'h23;
    localparam logic [5:0] ADDR_THR  = 6'h24;
    localparam logic [5:0] ADDR_LOOP = 6'h25;
    localparam logic [5:0] ADDR_STEP = 6'h26;

    // ------------------------------------------------------------
    // Front-end gain modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_LOW  = 2'h1;
    localparam logic [1:0] MODE_MID  = 2'h2;
    localparam logic [1:0] MODE_HIGH = 2'h3;

    // ------------------------------------------------------------
    // Loop constants
    // ------------------------------------------------------------
    localparam logic [6:0]        VGA_RESET   = 7'h7f;
    localparam logic signed [8:0] VGA_MAX     = 9'sh07f;
    localparam logic signed [8:0] STAGE_DROP  = 9'sh007; // 14 dB in 2 dB units
    localparam logic [6:0]        WIN_MIN     = 7'h08;
    localparam logic [3:0]        WIN_LOG_MIN = 4'h3;
    localparam logic [7:0]        SETTLE_CYC_0 = 8'h08;
    localparam logic [7:0]        SETTLE_CYC_1 = 8'h10;
    localparam logic [7:0]        SETTLE_CYC_2 = 8'h20;
    localparam logic [7:0]        SETTLE_CYC_3 = 8'h40;

    // ------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] rsvd;
        logic       vga_override_en;
        logic [6:0] vga_gain;
        logic [1:0] frontend_mode_override;
        logic [1:0] frontend_mode_current;
    } rgcr_ctrl_t;

    typedef struct packed {
        logic [3:0] frontend_mode_hysteresis;
        logic [5:0] mid_high_threshold;
        logic [5:0] low_mid_threshold;
    } rgcr_thr_t;

    typedef struct packed {
        logic       rsvd;
        logic       blanking_select;
        logic       detector_bias_double;
        logic [1:0] gain_settle_time;
        logic [2:0] detector_enable_set;
        logic [1:0] accumulate_window_len;
        logic [5:0] loop_target_level;
    } rgcr_loop_t;

    typedef struct packed {
        logic [5:0] rsvd;
        logic [4:0] mid_to_high_gain_step;
        logic [4:0] low_to_mid_gain_step;
    } rgcr_step_t;

    localparam rgcr_thr_t  THR_RESET  = '{4'h3, 6'h19, 6'h09};
    localparam rgcr_loop_t LOOP_RESET = '{1'h0, 1'h0, 1'h0, 2'h1, 3'h0, 2'h1, 6'h14};
    localparam rgcr_step_t STEP_RESET = '{6'h00, 5'h09, 5'h0a};

endpackage
`default_nettype wire

// ### rtl/rgcr_loop_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rgcr_loop_if;
    logic       smp_valid;
    logic [5:0] smp_level;
    logic [1:0] win_sel;
    logic       acc_clear;
    logic       dump_valid;
    logic [5:0] dump_level;
    logic       settle_start;
    logic [1:0] settle_sel;
    logic       settle_busy;

    modport core (output smp_valid, smp_level, win_sel, acc_clear,
                  output settle_start, settle_sel,
                  input  dump_valid, dump_level, settle_busy);
    modport acc  (input  smp_valid, smp_level, win_sel, acc_clear,
                  output dump_valid, dump_level);
    modport settle (input settle_start, settle_sel, output settle_busy);
endinterface
`default_nettype wire

// ### rtl/rgcr_accum.sv
`timescale 1ns/100ps
`default_nettype none
module rgcr_accum (
    input  wire logic clk,
    input  wire logic rst,
    rgcr_loop_if.acc  lp
);
    typedef struct packed {
        logic [11:0] sum;
        logic [6:0]  cnt;
        logic        dv;
        logic [5:0]  lvl;
    } rgcr_acc_st_t;

    rgcr_acc_st_t q;
    rgcr_acc_st_t d;
    logic [11:0]  tot;
    logic [6:0]   len;
    logic [3:0]   sh;

    // ------------------------------------------------------------
    // Accumulate and dump
    // ------------------------------------------------------------
    always_comb begin
        d   = q;
        d.dv = 1'b0;
        len = WIN_MIN_SHL(lp.win_sel);
        sh  = rgcr_pkg::WIN_LOG_MIN + {2'h0, lp.win_sel};
        tot = q.sum + {6'h00, lp.smp_level};
        if (lp.acc_clear) begin
            d.sum = '0;
            d.cnt = '0;
        end else if (lp.smp_valid) begin
            d.sum = tot;
            d.cnt = q.cnt + 7'h01;
            if (d.cnt == len) begin
                d.dv  = 1'b1;
                d.lvl = 6'(tot >> sh);
                d.sum = '0;
                d.cnt = '0;
            end
        end
    end

    function automatic logic [6:0] WIN_MIN_SHL(input logic [1:0] s);
        WIN_MIN_SHL = rgcr_pkg::WIN_MIN << s;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lp.dump_valid = q.dv;
    assign lp.dump_level = q.lvl;
endmodule // rgcr_accum
`default_nettype wire

// ### rtl/rgcr_settle.sv
`timescale 1ns/100ps
`default_nettype none
module rgcr_settle (
    input  wire logic   clk,
    input  wire logic   rst,
    rgcr_loop_if.settle lp
);
    typedef struct packed {
        logic [7:0] cnt;
    } rgcr_set_st_t;

    rgcr_set_st_t q;
    rgcr_set_st_t d;

    // ------------------------------------------------------------
    // Settling countdown
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (lp.settle_start) begin
            case (lp.settle_sel)
                2'h0:    d.cnt = rgcr_pkg::SETTLE_CYC_0;
                2'h1:    d.cnt = rgcr_pkg::SETTLE_CYC_1;
                2'h2:    d.cnt = rgcr_pkg::SETTLE_CYC_2;
                default: d.cnt = rgcr_pkg::SETTLE_CYC_3;
            endcase
        end else if (q.cnt != 8'h00) begin
            d.cnt = q.cnt - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lp.settle_busy = (q.cnt != 8'h00);
endmodule // rgcr_settle
`default_nettype wire

// ### tb/rgcr_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rgcr_top_assertions (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        rx_active,
    input  wire logic        det_valid,
    input  wire logic [5:0]  det_adc_level,
    input  wire logic [5:0]  det_fixed_level,
    input  wire logic [5:0]  det_var_level,
    input  wire logic [6:0]  vga_gain_out,
    input  wire logic [1:0]  frontend_mode_out,
    input  wire logic [2:0]  detector_enable_out,
    input  wire logic        detector_bias_double_out,
    input  wire logic        vga_blank_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Write followed by a quiet spell
    // ------------------------------------------------------------
    sequence s_no_write;
        !reg_wr [*3];
    endsequence

    sequence s_no_write_rx;
        (!reg_wr && rx_active) [*3];
    endsequence

    property p_loop_copy;
        logic [15:0] v;
        (reg_wr && reg_addr == rgcr_pkg::ADDR_LOOP, v = reg_wdata) ##1 s_no_write
            |-> detector_bias_double_out == v[13] && detector_enable_out == v[10:8];
    endproperty

    property p_gain_forced;
        logic [6:0] v;
        (reg_wr && reg_addr == rgcr_pkg::ADDR_CTRL && reg_wdata[11], v = reg_wdata[10:4])
            ##1 s_no_write |-> vga_gain_out == v;
    endproperty

    property p_mode_forced;
        logic [1:0] m;
        (reg_wr && reg_addr == rgcr_pkg::ADDR_CTRL && reg_wdata[3:2] != rgcr_pkg::MODE_AUTO,
            m = reg_wdata[3:2]) ##1 s_no_write_rx |-> frontend_mode_out == m;
    endproperty

    chk_reset_values: assert property (@(posedge clk) disable iff (1'b0)
        $fell(rst) |-> reg_rdata == 16'h0000 && vga_gain_out == rgcr_pkg::VGA_RESET
            && frontend_mode_out == 2'h0 && !vga_blank_out)
        else $error("outputs wrong after reset");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_bias_copy: assert property (p_loop_copy)
        else $error("detector controls do not follow register");
    chk_gain_forced: assert property (p_gain_forced)
        else $error("override gain not applied");
    chk_mode_forced: assert property (p_mode_forced)
        else $error("forced front-end mode not applied");
    chk_unmapped_zero: assert property (reg_rd && (reg_addr < rgcr_pkg::ADDR_CTRL
        || reg_addr > rgcr_pkg::ADDR_STEP) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_status_readback: assert property (reg_rd && reg_addr == rgcr_pkg::ADDR_CTRL
        ##1 ($stable(vga_gain_out) && $stable(frontend_mode_out))
        |-> reg_rdata[15:12] == 4'h0 && reg_rdata[10:4] == vga_gain_out
            && reg_rdata[1:0] == frontend_mode_out)
        else $error("control readback differs from gain in use");
    chk_blank_needs_drop: assert property ($rose(vga_blank_out)
        |-> $past(vga_gain_out) > vga_gain_out || $past(frontend_mode_out) > frontend_mode_out
            || $past(vga_gain_out, 2) > $past(vga_gain_out))
        else $error("blanking without a gain drop");
endmodule // rgcr_top_assertions

bind rgcr_top rgcr_top_assertions i_chk (
    .clk                      (clk),
    .rst                      (rst),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_rdata                (reg_rdata),
    .rx_active                (rx_active),
    .det_valid                (det_valid),
    .det_adc_level            (det_adc_level),
    .det_fixed_level          (det_fixed_level),
    .det_var_level            (det_var_level),
    .vga_gain_out             (vga_gain_out),
    .frontend_mode_out        (frontend_mode_out),
    .detector_enable_out      (detector_enable_out),
    .detector_bias_double_out (detector_bias_double_out),
    .vga_blank_out            (vga_blank_out)
);
`default_nettype wire

// ### tb/rgcr_frontend_model.sv
`timescale 1ns/100ps
`default_nettype none
module rgcr_frontend_model (
    input  wire logic       clk,
    input  wire logic       rx_active,
    input  wire logic       slow,
    input  wire logic [6:0] vga_gain,
    input  wire logic [5:0] sig_level,
    output var  logic       det_valid,
    output var  logic [5:0] adc_level,
    output var  logic [5:0] fixed_level,
    output var  logic [5:0] var_level
);
    logic [7:0] sum;
    logic [1:0] div;

    // Level seen by the detectors grows with the applied gain
    initial begin
        det_valid = 1'b0;
        adc_level = 6'h00;
        fixed_level = 6'h15;
        var_level = 6'h2a;
        div = 2'h0;
    end

    always @(negedge clk) begin
        sum = {2'h0, sig_level} + {3'h0, vga_gain[6:2]};
        div <= div + 2'h1;
        if (rx_active) begin
            det_valid <= !slow || div == 2'h0;
            adc_level <= (sum > 8'h3f) ? 6'h3f : sum[5:0];
            fixed_level <= (sum > 8'h40) ? 6'h3f : sum[5:0] - 6'h01;
            var_level <= (sum > 8'h41) ? 6'h3f : sum[5:0] - 6'h02;
        end else begin
            // Idle lines toggle between the last level and its inverse, det_valid low
            det_valid <= 1'b0;
            adc_level <= ~adc_level;
            fixed_level <= ~fixed_level;
            var_level <= ~var_level;
        end
    end
endmodule // rgcr_frontend_model
`default_nettype wire

// ### tb/rx_gain_control_registers_test.sv
`timescale 1ns/100ps
`default_nettype none
module rx_gain_control_registers_test;
    logic        clk;
    logic        rst;
    logic        reg_wr;
    logic        reg_rd;
    logic [5:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        rx_active;
    logic        slow;
    logic        det_valid;
    logic [5:0]  det_adc_level;
    logic [5:0]  det_fixed_level;
    logic [5:0]  det_var_level;
    logic [6:0]  vga_gain_out;
    logic [1:0]  frontend_mode_out;
    logic [2:0]  detector_enable_out;
    logic        detector_bias_double_out;
    logic        vga_blank_out;
    logic [5:0]  sig_level;
    logic        rd_seen;
    logic        saw;
    logic [15:0] v;
    logic [31:0] seed;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    int          fails;
    int          tests_run;

    rgcr_top i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_active(rx_active), .det_valid(det_valid), .det_adc_level(det_adc_level),
        .det_fixed_level(det_fixed_level), .det_var_level(det_var_level),
        .vga_gain_out(vga_gain_out), .frontend_mode_out(frontend_mode_out),
        .detector_enable_out(detector_enable_out),
        .detector_bias_double_out(detector_bias_double_out), .vga_blank_out(vga_blank_out));

    rgcr_frontend_model i_fe (.clk(clk), .rx_active(rx_active), .slow(slow),
        .vga_gain(vga_gain_out), .sig_level(sig_level), .det_valid(det_valid),
        .adc_level(det_adc_level), .fixed_level(det_fixed_level), .var_level(det_var_level));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [15:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    task automatic tally_and_finish();
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp_reg(input logic [15:0] e, input logic [15:0] m);
        tests_run++;
        if ((reg_rdata & m) !== (e & m)) begin
            fails++;
            $display("ERROR reg_rdata expected %h seen %h", e & m, reg_rdata & m);
        end
    endtask

    task automatic cmp_out(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    // ------------------------------------------------------------
    // Register access, driven at the falling edge
    // ------------------------------------------------------------
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic [15:0] m);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(negedge clk);
        reg_rd = 1'b0;
    endtask

    task automatic watch_blank(input int n);
        saw = 1'b0;
        repeat (n) begin
            @(negedge clk);
            saw = saw | vga_blank_out;
        end
    endtask

    // ------------------------------------------------------------
    // Read data monitor
    // ------------------------------------------------------------
    always @(posedge clk) rd_seen <= reg_rd;

    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            cmp_reg(exp_q[0], msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    initial begin
        #50000;
        fails++;
        tally_and_finish();
    end

    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 24'h000000};
        {rx_active, slow, sig_level, fails, tests_run} = '0;
        seed = 32'h6b4e;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rd(rgcr_pkg::ADDR_CTRL, 16'h07f0, 16'hffff);
        rd(rgcr_pkg::ADDR_THR, 16'h3649, 16'hffff);
        rd(rgcr_pkg::ADDR_LOOP, 16'h0854, 16'hffff);
        rd(rgcr_pkg::ADDR_STEP, 16'h012a, 16'hffff);
        rd(6'h22, 16'h0000, 16'hffff);
        for (int i = 0; i < 6; i++) begin
            v = xorshift();
            wr(rgcr_pkg::ADDR_THR, v);
            wr(rgcr_pkg::ADDR_STEP, v & 16'h03ff);
            wr(6'h27, v);
            wr(rgcr_pkg::ADDR_LOOP, v & 16'h7fff);
            rd(rgcr_pkg::ADDR_THR, v, 16'hffff);
            rd(rgcr_pkg::ADDR_LOOP, v, 16'h7fff);
            rd(rgcr_pkg::ADDR_STEP, v, 16'h03ff);
            rd(6'h27, 16'h0000, 16'hffff);
            cmp_out("detector_enable_out", {5'h0, v[10:8]}, {5'h0, detector_enable_out});
            cmp_out("detector_bias_double_out", 8'(v[13]), 8'(detector_bias_double_out));
        end
        wr(rgcr_pkg::ADDR_LOOP, 16'h4714);
        rx_active = 1'b1;
        for (int m = 1; m < 4; m++) begin
            v = xorshift();
            wr(rgcr_pkg::ADDR_CTRL, {4'h0, 1'b1, v[6:0], m[1:0], 2'h0});
            rd(rgcr_pkg::ADDR_CTRL, {4'h0, 1'b1, v[6:0], m[1:0], m[1:0]}, 16'hffff);
            cmp_out("vga_gain_out", {1'b0, v[6:0]}, {1'b0, vga_gain_out});
            cmp_out("frontend_mode_out", {6'h0, m[1:0]}, {6'h0, frontend_mode_out});
        end
        for (int s = 0; s < 2; s++) begin
            wr(rgcr_pkg::ADDR_LOOP, {1'b0, s[0], 14'h0714});
            wr(rgcr_pkg::ADDR_CTRL, 16'h0ffc);
            repeat (100) @(negedge clk);
            wr(rgcr_pkg::ADDR_CTRL, 16'h080c);
            watch_blank(20);
            cmp_out("vga_blank_out", {7'h0, s[0]}, {7'h0, saw});
        end
        repeat (100) @(negedge clk);
        wr(rgcr_pkg::ADDR_LOOP, 16'h0714);
        slow = 1'b1;
        sig_level = 6'h30;
        wr(rgcr_pkg::ADDR_CTRL, 16'h07f0);
        watch_blank(600);
        cmp_out("vga_blank_out", 8'h01, {7'h0, saw});
        cmp_out("vga_gain_low", 8'h01, {7'h0, vga_gain_out < 7'h30});
        rd(rgcr_pkg::ADDR_CTRL, 16'h0000, 16'hf80c);
        repeat (4) @(negedge clk);
        tally_and_finish();
    end
endmodule // rx_gain_control_registers_test
`default_nettype wire
